// >>> cg_pkg.sv
// constants for the clock source and pll setting registers
package cg_pkg;
    localparam int unsigned ADDR_W       = 9;
    localparam int unsigned IDX_W        = 7;
    // register indexes; byte address is four times the index
    localparam logic [6:0]  IDX_PAGE     = 7'h00;
    localparam logic [6:0]  IDX_RSVD_A   = 7'h03;
    localparam logic [6:0]  IDX_SRC      = 7'h04;
    localparam logic [6:0]  IDX_PWR_PDIV = 7'h05;
    localparam logic [6:0]  IDX_JMUL     = 7'h06;
    localparam logic [6:0]  IDX_FRAC_UP  = 7'h07;
    localparam logic [6:0]  IDX_FRAC_LO  = 7'h08;
    localparam logic [6:0]  IDX_RSVD_B0  = 7'h09;
    localparam logic [6:0]  IDX_RSVD_B1  = 7'h0A;
    localparam logic [7:0]  PAGE_CLOCK   = 8'h00;
    // field positions
    localparam int unsigned RANGE_BIT    = 6;
    localparam int unsigned REF_LSB      = 2;
    localparam int unsigned SRC_LSB      = 0;
    localparam int unsigned PWR_BIT      = 7;
    localparam int unsigned PDIV_LSB     = 4;
    localparam int unsigned RMUL_LSB     = 0;
    localparam int unsigned JMUL_LSB     = 0;
    localparam int unsigned FUP_LSB      = 0;
    // reset values
    localparam logic [7:0]  PAGE_RST     = 8'h00;
    localparam logic        RANGE_RST    = 1'h0;
    localparam logic [1:0]  REF_RST      = 2'h0;
    localparam logic [1:0]  SRC_RST      = 2'h0;
    localparam logic        PWR_RST      = 1'h0;
    localparam logic [2:0]  PDIV_RST     = 3'h1;
    localparam logic [3:0]  RMUL_RST     = 4'h1;
    localparam logic [5:0]  JMUL_RST     = 6'h04;
    localparam logic [5:0]  FUP_RST      = 6'h00;
    localparam logic [7:0]  FLO_RST      = 8'h00;
    // axi responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;

    function automatic logic idx_mapped(input logic [6:0] idx);
        idx_mapped = (idx == IDX_PAGE) || ((idx >= IDX_RSVD_A) && (idx <= IDX_RSVD_B1));
    endfunction

    // pre-divider code 0 means eight
    function automatic logic [3:0] p_decode(input logic [2:0] code);
        p_decode = (code == 3'h0) ? 4'h8 : {1'b0, code};
    endfunction
endpackage

// >>> cg_axil_port.sv
// axi4-lite slave front end producing single-cycle register strobes
`timescale 1ns/10ps
`default_nettype none
module cg_axil_port (
    input  wire logic        clk_i,         // clock
    input  wire logic        reset_n_i,     // sync reset, low
    input  wire logic [8:0]  awaddr_i,      // write address
    input  wire logic        awvalid_i,     // write address valid
    output logic             awready_o,     // write address ready
    input  wire logic [31:0] wdata_i,       // write data
    input  wire logic [3:0]  wstrb_i,       // write strobes
    input  wire logic        wvalid_i,      // write data valid
    output logic             wready_o,      // write data ready
    output logic [1:0]       bresp_o,       // write response
    output logic             bvalid_o,      // write response valid
    input  wire logic        bready_i,      // write response ready
    input  wire logic [8:0]  araddr_i,      // read address
    input  wire logic        arvalid_i,     // read address valid
    output logic             arready_o,     // read address ready
    output logic [31:0]      rdata_o,       // read data
    output logic [1:0]       rresp_o,       // read response
    output logic             rvalid_o,      // read data valid
    input  wire logic        rready_i,      // read data ready
    output logic             wr_en_o,       // register write strobe
    output logic [6:0]       wr_idx_o,      // register index written
    output logic [7:0]       wr_data_o,     // low byte written
    output logic             wr_lane0_o,    // byte lane 0 enabled
    output logic [6:0]       rd_idx_o,      // register index to read
    input  wire logic [7:0]  rd_data_i      // read value of rd_idx_o
);
    logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [6:0]  awidx_r, awidx_nxt;
    logic [7:0]  wdat_r, wdat_nxt;
    logic        wlane_r, wlane_nxt;
    logic        awready_r, awready_nxt, wready_r, wready_nxt;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, arready_r, arready_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        exec;

    assign exec     = aw_hold_r && w_hold_r && !bvalid_r;
    assign rd_idx_o = araddr_i[8:2];

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        awidx_nxt   = awidx_r;
        wdat_nxt    = wdat_r;
        wlane_nxt   = wlane_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (awvalid_i && awready_r) begin
            aw_hold_nxt = 1'b1;
            awidx_nxt   = awaddr_i[8:2];
        end
        if (wvalid_i && wready_r) begin
            w_hold_nxt = 1'b1;
            wdat_nxt   = wdata_i[7:0];
            wlane_nxt  = wstrb_i[0];
        end
        if (bvalid_r && bready_i) begin
            bvalid_nxt = 1'b0;
        end
        if (exec) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = cg_pkg::idx_mapped(awidx_r) ? cg_pkg::RESP_OKAY : cg_pkg::RESP_DECERR;
        end
        if (rvalid_r && rready_i) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid_i && arready_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = {24'h00_0000, rd_data_i};
            rresp_nxt  = cg_pkg::idx_mapped(araddr_i[8:2]) ? cg_pkg::RESP_OKAY : cg_pkg::RESP_DECERR;
        end
        awready_nxt = !aw_hold_nxt;
        wready_nxt  = !w_hold_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awidx_r   <= 7'h00;
            wdat_r    <= 8'h00;
            wlane_r   <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            arready_r <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            rvalid_r  <= 1'b0;
            rresp_r   <= 2'h0;
            rdata_r   <= 32'h0000_0000;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            awidx_r   <= awidx_nxt;
            wdat_r    <= wdat_nxt;
            wlane_r   <= wlane_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            arready_r <= arready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign awready_o  = awready_r;
    assign wready_o   = wready_r;
    assign arready_o  = arready_r;
    assign bvalid_o   = bvalid_r;
    assign bresp_o    = bresp_r;
    assign rvalid_o   = rvalid_r;
    assign rresp_o    = rresp_r;
    assign rdata_o    = rdata_r;
    assign wr_en_o    = exec;
    assign wr_idx_o   = awidx_r;
    assign wr_data_o  = wdat_r;
    assign wr_lane0_o = wlane_r;
endmodule
`default_nettype wire

// >>> cg_frac_stage.sv
// double-buffered fractional multiplier: upper part waits for the lower write
`timescale 1ns/10ps
`default_nettype none
module cg_frac_stage (
    input  wire logic        clk_i,       // clock
    input  wire logic        reset_n_i,   // sync reset, low
    input  wire logic        wr_any_i,    // any register write taken
    input  wire logic        wr_upper_i,  // write to upper part
    input  wire logic        wr_lower_i,  // write to lower part
    input  wire logic [7:0]  wr_data_i,   // written byte
    output logic [5:0]       upper_o,     // last written upper part
    output logic             pending_o,   // upper part waiting
    output logic [13:0]      frac_o       // applied fractional value
);
    logic [5:0]  upper_r, upper_nxt;
    logic        pend_r, pend_nxt;
    logic [13:0] frac_r, frac_nxt;

    always_comb begin
        upper_nxt = upper_r;
        pend_nxt  = pend_r;
        frac_nxt  = frac_r;
        if (wr_any_i) begin
            // any write other than to the upper part drops the pending upper part
            pend_nxt = 1'b0;
        end
        if (wr_upper_i) begin
            upper_nxt = wr_data_i[cg_pkg::FUP_LSB +: 6];
            pend_nxt  = 1'b1;
        end
        if (wr_lower_i) begin
            frac_nxt = {pend_r ? upper_r : frac_r[13:8], wr_data_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            upper_r <= cg_pkg::FUP_RST;
            pend_r  <= 1'b0;
            frac_r  <= {cg_pkg::FUP_RST, cg_pkg::FLO_RST};
        end else begin
            upper_r <= upper_nxt;
            pend_r  <= pend_nxt;
            frac_r  <= frac_nxt;
        end
    end

    assign upper_o   = upper_r;
    assign pending_o = pend_r;
    assign frac_o    = frac_r;
endmodule
`default_nettype wire

// >>> cg_clock_regs.sv
// clock source select and pll setting registers behind axi4-lite
//
// Overview of operation
// - range bit picks low or high pll range
// - two-bit code picks the pll reference pin
// - two-bit code picks the codec clock source
// - pll stays down until power bit set
// - pre-divider codes 1-7 direct, zero means eight
// - upper fraction applied only if the next write is to the lower part
// - accesses go to the selected page, zero
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module cg_clock_regs (
    input  wire logic        CLK_I,                // 40 MHz clock
    input  wire logic        RESET_N_I,            // sync reset, low
    input  wire logic [8:0]  AWADDR,               // write address
    input  wire logic        AWVALID,              // write address valid
    output logic             AWREADY,              // write address ready
    input  wire logic [31:0] WDATA,                // write data
    input  wire logic [3:0]  WSTRB,                // write strobes
    input  wire logic        WVALID,               // write data valid
    output logic             WREADY,               // write data ready
    output logic [1:0]       BRESP,                // write response
    output logic             BVALID,               // write response valid
    input  wire logic        BREADY,               // write response ready
    input  wire logic [8:0]  ARADDR,               // read address
    input  wire logic        ARVALID,              // read address valid
    output logic             ARREADY,              // read address ready
    output logic [31:0]      RDATA,                // read data
    output logic [1:0]       RRESP,                // read response
    output logic             RVALID,               // read data valid
    input  wire logic        RREADY,               // read data ready
    output logic             PLL_POWER_UP_O,       // pll powered up
    output logic             PLL_RANGE_HIGH_O,     // high pll clock range
    output logic [1:0]       PLL_REF_SEL_O,        // pll reference pin code
    output logic [1:0]       CODEC_CLOCK_SOURCE_O, // codec clock source code
    output logic [3:0]       PLL_P_DIV_O,          // pre-divider value 1..8
    output logic [3:0]       PLL_R_MUL_O,          // multiplier r
    output logic [5:0]       PLL_J_MUL_O,          // integer multiplier j
    output logic [13:0]      PLL_D_FRAC_O,         // fractional multiplier d
    output logic [7:0]       PAGE_O                // selected page
);
    logic        wr_en;
    logic [6:0]  wr_idx;
    logic [7:0]  wr_data;
    logic        wr_lane0;
    logic [6:0]  rd_idx;
    logic [7:0]  rd_data;
    logic        wr_take;
    logic        on_clock_page;
    logic        wr_upper;
    logic        wr_lower;
    logic [5:0]  frac_upper;
    logic        frac_pending;

    logic [7:0]  page_r, page_nxt;
    logic        range_r, range_nxt;
    logic [1:0]  ref_r, ref_nxt;
    logic [1:0]  src_r, src_nxt;
    logic        pwr_r, pwr_nxt;
    logic [2:0]  pcode_r, pcode_nxt;
    logic [3:0]  pdiv_r, pdiv_nxt;
    logic [3:0]  rmul_r, rmul_nxt;
    logic [5:0]  jmul_r, jmul_nxt;

    cg_axil_port u_port (
        .clk_i      (CLK_I),
        .reset_n_i  (RESET_N_I),
        .awaddr_i   (AWADDR),
        .awvalid_i  (AWVALID),
        .awready_o  (AWREADY),
        .wdata_i    (WDATA),
        .wstrb_i    (WSTRB),
        .wvalid_i   (WVALID),
        .wready_o   (WREADY),
        .bresp_o    (BRESP),
        .bvalid_o   (BVALID),
        .bready_i   (BREADY),
        .araddr_i   (ARADDR),
        .arvalid_i  (ARVALID),
        .arready_o  (ARREADY),
        .rdata_o    (RDATA),
        .rresp_o    (RRESP),
        .rvalid_o   (RVALID),
        .rready_i   (RREADY),
        .wr_en_o    (wr_en),
        .wr_idx_o   (wr_idx),
        .wr_data_o  (wr_data),
        .wr_lane0_o (wr_lane0),
        .rd_idx_o   (rd_idx),
        .rd_data_i  (rd_data)
    );

    // a write without byte lane 0 changes nothing
    assign wr_take       = wr_en && wr_lane0;
    assign on_clock_page = (page_r == cg_pkg::PAGE_CLOCK);
    assign wr_upper      = wr_take && on_clock_page && (wr_idx == cg_pkg::IDX_FRAC_UP);
    assign wr_lower      = wr_take && on_clock_page && (wr_idx == cg_pkg::IDX_FRAC_LO);

    cg_frac_stage u_frac (
        .clk_i      (CLK_I),
        .reset_n_i  (RESET_N_I),
        .wr_any_i   (wr_take),
        .wr_upper_i (wr_upper),
        .wr_lower_i (wr_lower),
        .wr_data_i  (wr_data),
        .upper_o    (frac_upper),
        .pending_o  (frac_pending),
        .frac_o     (PLL_D_FRAC_O)
    );

    always_comb begin
        page_nxt  = page_r;
        range_nxt = range_r;
        ref_nxt   = ref_r;
        src_nxt   = src_r;
        pwr_nxt   = pwr_r;
        pcode_nxt = pcode_r;
        rmul_nxt  = rmul_r;
        jmul_nxt  = jmul_r;
        if (wr_take && (wr_idx == cg_pkg::IDX_PAGE)) begin
            page_nxt = wr_data;
        end else if (wr_take && on_clock_page) begin
            // reserved indexes and bits are dropped
            case (wr_idx)
                cg_pkg::IDX_SRC: begin
                    range_nxt = wr_data[cg_pkg::RANGE_BIT];
                    ref_nxt   = wr_data[cg_pkg::REF_LSB +: 2];
                    src_nxt   = wr_data[cg_pkg::SRC_LSB +: 2];
                end
                cg_pkg::IDX_PWR_PDIV: begin
                    pwr_nxt   = wr_data[cg_pkg::PWR_BIT];
                    pcode_nxt = wr_data[cg_pkg::PDIV_LSB +: 3];
                    rmul_nxt  = wr_data[cg_pkg::RMUL_LSB +: 4];
                end
                cg_pkg::IDX_JMUL: begin
                    jmul_nxt  = wr_data[cg_pkg::JMUL_LSB +: 6];
                end
                default: begin
                    page_nxt = page_r;
                end
            endcase
        end
        pdiv_nxt = cg_pkg::p_decode(pcode_nxt);
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            page_r  <= cg_pkg::PAGE_RST;
            range_r <= cg_pkg::RANGE_RST;
            ref_r   <= cg_pkg::REF_RST;
            src_r   <= cg_pkg::SRC_RST;
            pwr_r   <= cg_pkg::PWR_RST;
            pcode_r <= cg_pkg::PDIV_RST;
            pdiv_r  <= cg_pkg::p_decode(cg_pkg::PDIV_RST);
            rmul_r  <= cg_pkg::RMUL_RST;
            jmul_r  <= cg_pkg::JMUL_RST;
        end else begin
            page_r  <= page_nxt;
            range_r <= range_nxt;
            ref_r   <= ref_nxt;
            src_r   <= src_nxt;
            pwr_r   <= pwr_nxt;
            pcode_r <= pcode_nxt;
            pdiv_r  <= pdiv_nxt;
            rmul_r  <= rmul_nxt;
            jmul_r  <= jmul_nxt;
        end
    end

    // read value; the page register reads on every page, other indexes on other pages and reserved bits show zero
    always_comb begin
        rd_data = 8'h00;
        if (rd_idx == cg_pkg::IDX_PAGE) begin
            rd_data = page_r;
        end else if (on_clock_page) begin
            case (rd_idx)
                cg_pkg::IDX_SRC: begin
                    rd_data[cg_pkg::RANGE_BIT]   = range_r;
                    rd_data[cg_pkg::REF_LSB +: 2] = ref_r;
                    rd_data[cg_pkg::SRC_LSB +: 2] = src_r;
                end
                cg_pkg::IDX_PWR_PDIV: begin
                    rd_data[cg_pkg::PWR_BIT]       = pwr_r;
                    rd_data[cg_pkg::PDIV_LSB +: 3] = pcode_r;
                    rd_data[cg_pkg::RMUL_LSB +: 4] = rmul_r;
                end
                cg_pkg::IDX_JMUL: begin
                    rd_data[cg_pkg::JMUL_LSB +: 6] = jmul_r;
                end
                cg_pkg::IDX_FRAC_UP: begin
                    rd_data[cg_pkg::FUP_LSB +: 6] = frac_upper;
                end
                cg_pkg::IDX_FRAC_LO: begin
                    rd_data = PLL_D_FRAC_O[7:0];
                end
                default: begin
                    rd_data = 8'h00;
                end
            endcase
        end
    end

    assign PAGE_O               = page_r;
    assign PLL_RANGE_HIGH_O     = range_r;
    assign PLL_REF_SEL_O        = ref_r;
    assign CODEC_CLOCK_SOURCE_O = src_r;
    assign PLL_POWER_UP_O       = pwr_r;
    assign PLL_P_DIV_O          = pdiv_r;
    assign PLL_R_MUL_O          = rmul_r;
    assign PLL_J_MUL_O          = jmul_r;

    // checks
    logic wr_clk_reg;
    assign wr_clk_reg = wr_take && on_clock_page;

    property p_range_follows;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (wr_clk_reg && wr_idx == cg_pkg::IDX_SRC) |=> (PLL_RANGE_HIGH_O == $past(wr_data[6]));
    endproperty
    a_range_follows: assert property (p_range_follows) else $error("range bit not taken");

    property p_ref_follows;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (wr_clk_reg && wr_idx == cg_pkg::IDX_SRC) |=> (PLL_REF_SEL_O == $past(wr_data[3:2]));
    endproperty
    a_ref_follows: assert property (p_ref_follows) else $error("pll reference code not taken");

    property p_src_follows;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (wr_clk_reg && wr_idx == cg_pkg::IDX_SRC) |=> (CODEC_CLOCK_SOURCE_O == $past(wr_data[1:0]));
    endproperty
    a_src_follows: assert property (p_src_follows) else $error("codec clock source not taken");

    property p_power_holds;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        !(wr_clk_reg && wr_idx == cg_pkg::IDX_PWR_PDIV) |=> (PLL_POWER_UP_O == $past(PLL_POWER_UP_O));
    endproperty
    a_power_holds: assert property (p_power_holds) else $error("pll power changed without write");

    property p_pdiv_decode;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (wr_clk_reg && wr_idx == cg_pkg::IDX_PWR_PDIV)
            |=> (PLL_P_DIV_O == (($past(wr_data[6:4]) == 3'h0) ? 4'h8 : {1'b0, $past(wr_data[6:4])}));
    endproperty
    a_pdiv_decode: assert property (p_pdiv_decode) else $error("pre-divider decode wrong");

    // last accepted write and the upper part it carried, for the pairing check
    logic        chk_up_last_r, chk_up_last_nxt;
    logic [5:0]  chk_up_val_r, chk_up_val_nxt;

    always_comb begin
        chk_up_last_nxt = chk_up_last_r;
        chk_up_val_nxt  = chk_up_val_r;
        if (wr_take) begin
            chk_up_last_nxt = wr_upper;
        end
        if (wr_upper) begin
            chk_up_val_nxt = wr_data[5:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            chk_up_last_r <= 1'b0;
            chk_up_val_r  <= 6'h00;
        end else begin
            chk_up_last_r <= chk_up_last_nxt;
            chk_up_val_r  <= chk_up_val_nxt;
        end
    end

    sequence s_upper_then_lower;
        chk_up_last_r ##0 wr_lower;
    endsequence

    property p_frac_pair;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        s_upper_then_lower |=> (PLL_D_FRAC_O == {$past(chk_up_val_r), $past(wr_data)});
    endproperty
    a_frac_pair: assert property (p_frac_pair) else $error("paired fraction not applied");

    property p_frac_upper_waits;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        wr_upper |=> (PLL_D_FRAC_O == $past(PLL_D_FRAC_O));
    endproperty
    a_frac_upper_waits: assert property (p_frac_upper_waits) else $error("upper fraction applied early");

    property p_frac_dropped;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (wr_take && !wr_upper && !wr_lower) |=> !frac_pending;
    endproperty
    a_frac_dropped: assert property (p_frac_dropped) else $error("pending upper survived other write");

    property p_other_page_ignored;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (wr_take && !on_clock_page && wr_idx != cg_pkg::IDX_PAGE)
            |=> $stable(PLL_POWER_UP_O) && $stable(PLL_J_MUL_O) && $stable(PLL_D_FRAC_O) && $stable(PAGE_O);
    endproperty
    a_other_page_ignored: assert property (p_other_page_ignored) else $error("write leaked off page");

    property p_reserved_reads_zero;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (ARVALID && ARREADY && (ARADDR[8:2] == cg_pkg::IDX_RSVD_A || ARADDR[8:2] == cg_pkg::IDX_RSVD_B0
            || ARADDR[8:2] == cg_pkg::IDX_RSVD_B1)) |=> (RVALID && RDATA == 32'h0000_0000);
    endproperty
    a_reserved_reads_zero: assert property (p_reserved_reads_zero) else $error("reserved read not zero");
endmodule
`default_nettype wire

// >>> test_pll_clock_source_config.sv
// self-checking bench for the clock source and pll setting registers
`timescale 1ns/10ps
`default_nettype none
module test_pll_clock_source_config;
    logic             CLK_I = 0, RESET_N_I = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [8:0]       AWADDR = 0, ARADDR = 0;
    logic [31:0]      WDATA = 0;
    logic [3:0]       WSTRB = 0;
    wire logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, pwr, rng;
    wire logic [1:0]  BRESP, RRESP, refs, srcs;
    wire logic [31:0] RDATA;
    wire logic [3:0]  pdiv, rmul;
    wire logic [5:0]  jmul;
    wire logic [13:0] dfrac;
    wire logic [7:0]  page;
    int               failures = 0, total_checks = 0, cycles = 0;
    logic [1:0]       rsp;
    logic [7:0]       rd, v, s_exp;
    logic [13:0]      d, d_exp;
    cg_clock_regs uut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .PLL_POWER_UP_O(pwr),
        .PLL_RANGE_HIGH_O(rng), .PLL_REF_SEL_O(refs), .CODEC_CLOCK_SOURCE_O(srcs), .PLL_P_DIV_O(pdiv),
        .PLL_R_MUL_O(rmul), .PLL_J_MUL_O(jmul), .PLL_D_FRAC_O(dfrac), .PAGE_O(page));
    initial begin
        forever #12.5 CLK_I = ~CLK_I;
    end
    function automatic logic [3:0] pexp(input logic [2:0] c);
        return (c == 3'h0) ? 4'h8 : {1'b0, c};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] dat, input logic [3:0] st);
        @(posedge CLK_I);
        AWADDR <= {idx, 2'b00};
        WDATA <= {24'h0, dat};
        WSTRB <= st;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        forever begin
            @(posedge CLK_I);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (BVALID === 1'b1) begin
                rsp = BRESP;
                BREADY <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rchk(input logic [6:0] idx, input logic [7:0] e);
        @(posedge CLK_I);
        ARADDR <= {idx, 2'b00};
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        forever begin
            @(posedge CLK_I);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (RVALID === 1'b1) begin
                rsp = RRESP;
                chk($sformatf("read idx %h", idx), {24'h0, e}, RDATA);
                RREADY <= 1'b0;
                break;
            end
        end
    endtask
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(39074));
        repeat (5) @(posedge CLK_I);
        RESET_N_I <= 1'b1;
        @(posedge CLK_I);
        chk("pdiv", 1, pdiv);
        chk("power", 0, pwr);
        chk("rmul", 1, rmul);
        chk("jmul", 4, jmul);
        for (int i = 0; i < 11; i++) begin
            rchk(i[6:0], (i == 5) ? 8'h11 : (i == 6) ? 8'h04 : 8'h00);
            chk("read resp", (i == 1 || i == 2) ? 2'h3 : 2'h0, rsp);
        end
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom) & 8'h4F;
            v[3:0] = i[3:0];
            v[6] = i[0] ^ i[2];
            wr(cg_pkg::IDX_SRC, v, 4'hF);
            s_exp = v & 8'h4F;
            chk("range", v[6], rng);
            chk("ref", v[3:2], refs);
            chk("source", v[1:0], srcs);
            rchk(cg_pkg::IDX_SRC, s_exp);
        end
        for (int i = 0; i < 8; i++) begin
            v = {i[1], i[2:0], 4'(1 + $urandom % 4)};
            wr(cg_pkg::IDX_PWR_PDIV, v, 4'hF);
            chk("pdiv", pexp(i[2:0]), pdiv);
            chk("power", v[7], pwr);
            chk("rmul", v[3:0], rmul);
            rchk(cg_pkg::IDX_PWR_PDIV, v);
            v = {2'b00, (i == 0) ? 6'd4 : (i == 1) ? 6'd63 : 6'(4 + $urandom % 60)};
            wr(cg_pkg::IDX_JMUL, v, 4'hF);
            chk("jmul", v[5:0], jmul);
            rchk(cg_pkg::IDX_JMUL, v & 8'h3F);
        end
        d_exp = 14'h0000;
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 14'd9999 : 14'($urandom % 10000);
            wr(cg_pkg::IDX_FRAC_UP, {2'b00, d[13:8]}, 4'hF);
            chk("frac held", d_exp, dfrac);
            rchk(cg_pkg::IDX_FRAC_UP, {2'b00, d[13:8]});
            wr(cg_pkg::IDX_FRAC_LO, d[7:0], 4'hF);
            d_exp = d;
            chk("frac applied", d_exp, dfrac);
            wr(cg_pkg::IDX_FRAC_UP, {2'b00, ~d[13:8]}, 4'hF);
            wr(cg_pkg::IDX_JMUL, 8'h04, 4'hF);
            wr(cg_pkg::IDX_FRAC_LO, ~d[7:0], 4'hF);
            d_exp[7:0] = ~d[7:0];
            chk("frac cancelled", d_exp, dfrac);
        end
        for (int i = 0; i < 3; i++) begin
            wr((i == 0) ? cg_pkg::IDX_RSVD_A : (i == 1) ? cg_pkg::IDX_RSVD_B0 : cg_pkg::IDX_RSVD_B1, 8'h00, 4'hF);
            rchk((i == 0) ? cg_pkg::IDX_RSVD_A : (i == 1) ? cg_pkg::IDX_RSVD_B0 : cg_pkg::IDX_RSVD_B1, 8'h00);
        end
        wr(7'h20, 8'h55, 4'hF);
        chk("unmapped resp", cg_pkg::RESP_DECERR, rsp);
        wr(cg_pkg::IDX_PAGE, 8'h01, 4'hF);
        chk("page", 1, page);
        wr(cg_pkg::IDX_SRC, ~s_exp, 4'hF);
        rchk(cg_pkg::IDX_SRC, 8'h00);
        wr(cg_pkg::IDX_PAGE, 8'h00, 4'hF);
        wr(cg_pkg::IDX_SRC, ~s_exp, 4'h0);
        rchk(cg_pkg::IDX_SRC, s_exp);
        chk("source kept", s_exp[1:0], srcs);
        report_and_stop();
    end
endmodule
`default_nettype wire
